// ===== flash_prot_pkg.sv
// constants, command codes and states for the status-register and protection block
// assumes one 125 MHz clock domain; nonvolatile bits are modelled as reset-loaded flops
package flash_prot_pkg;
   localparam int SR_BUSY_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_BP_LO = 2;
   localparam int SR_TB_BIT = 5;
   localparam int SR_BP_HI = 6;
   localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;
   localparam int FSR_READY_BIT = 7;
   localparam logic STATUS_WRITE_DISABLE_RESET = 1'b0;
   localparam logic TB_RESET = 1'b0;
   localparam logic [3:0] BP_RESET = 4'h0;
   localparam logic WEL_RESET = 1'b0;
   localparam logic BUSY_RESET = 1'b0;
   localparam int ADDR_W = 25;
   localparam int BLK128_LSB = 17;
   localparam int SEC64_LSB = 16;
   localparam int SUB32_LSB = 15;
   localparam int SUB4_LSB = 12;
   localparam int BANK_LSB_256 = 23;
   localparam int BANK_LSB_128 = 22;
   localparam logic [8:0] BLOCKS_256 = 9'h100;
   localparam logic [8:0] BLOCKS_128 = 9'h080;
   localparam logic [3:0] BP_ALL_CODE = 4'h9;
   localparam logic [15:0] SFDP_PARAM_ID = 16'hFF00;
   localparam logic [7:0] SFDP_TABLE_PTR = 8'h30;
   localparam logic [7:0] SFDP_TABLE_DWORDS = 8'h02;
   localparam logic [31:0] SFDP_DENSITY_256 = 32'h0FFFFFFF;
   localparam logic [31:0] SFDP_DENSITY_128 = 32'h07FFFFFF;
   localparam int WRSR_CYCLES_DEF = 16;
   localparam int NVCFG_CYCLES_DEF = 16;
   localparam int PROG_CYCLES_DEF = 32;
   localparam int ERASE_CYCLES_DEF = 64;

   typedef enum logic [3:0] {
      CMD_READ_STATUS = 4'h0,
      CMD_WRITE_STATUS = 4'h1,
      CMD_WRITE_ENABLE = 4'h2,
      CMD_WRITE_DISABLE = 4'h3,
      CMD_PROGRAM = 4'h4,
      CMD_ERASE_SECTOR = 4'h5,
      CMD_ERASE_SUB32 = 4'h6,
      CMD_ERASE_SUB4 = 4'h7,
      CMD_ERASE_CHIP = 4'h8,
      CMD_WRITE_NVCFG = 4'h9,
      CMD_READ_FLAG = 4'hA
   } cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } state_t;
endpackage

// ===== flash_status_protect_banking.sv
// status register, write protection, bank/sector mapping and parameter table of a serial flash
// assumes the command decoder hands over whole commands on cmd_valid/cmd_ready and that the
// array engine acts on op_start; wp_n is a pin and is synchronised here
// Functional notes
// - 128KB sectors: four banks of 64 or 32 consecutive sectors per density.
// - 64KB sectors: four banks of 128 or 64 consecutive sectors per density.
// - 64KB sector holds two 32KB subsectors, each holding eight 4KB subsectors, linear.
// - parameter table carries the standard header with identifier FF00h and basic table.
// - read-status returns the register, write-status updates it.
// - disable bit set with protect pin low blocks every status write.
// - only raising the protect pin or a reset leaves hardware protection; no command does.
// - status write disable bit is nonvolatile, defaults to 0 (writes enabled).
// - top/bottom bit 5 picks protected area end; 0 top by default.
// - block protect bits 6 and 4:2 define area refused to program/erase.
// - write enable latch is volatile and clear after power-up.
// - write, program and erase run only while write enable latch is set.
// - busy bit 0 is 1 during status, config write, program or erase.
// - busy bit always reads as inverse of flag status bit 7.
// - chip erase runs only when all block protect bits are zero.
// - code n protects 2^(n-1) 128KB blocks; 9 and above protect all.
`timescale 1ns/1ns
module flash_status_protect_banking #(
   parameter bit DENSITY_256 = 1'b1,
   parameter bit SECTOR_64K = 1'b0,
   parameter int WRSR_CYCLES = flash_prot_pkg::WRSR_CYCLES_DEF,
   parameter int NVCFG_CYCLES = flash_prot_pkg::NVCFG_CYCLES_DEF,
   parameter int PROG_CYCLES = flash_prot_pkg::PROG_CYCLES_DEF,
   parameter int ERASE_CYCLES = flash_prot_pkg::ERASE_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wp_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire flash_prot_pkg::cmd_t cmd_op,
   input wire logic [flash_prot_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] status_rdata,
   output logic [7:0] flag_rdata,
   output logic rdata_valid,
   output logic op_start,
   output flash_prot_pkg::cmd_t op_kind,
   output logic [flash_prot_pkg::ADDR_W-1:0] op_addr,
   output logic op_refused,
   output logic [1:0] bank_sel,
   output logic [8:0] sector_idx,
   output logic [9:0] sub32_idx,
   output logic [12:0] sub4_idx,
   output logic busy,
   input wire logic [7:0] sfdp_addr,
   output logic [7:0] sfdp_data
);
   import flash_prot_pkg::*;

   if (WRSR_CYCLES < 1 || NVCFG_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
       WRSR_CYCLES > 65535 || NVCFG_CYCLES > 65535 || PROG_CYCLES > 65535 || ERASE_CYCLES > 65535) begin : g_chk
      $error("busy cycle counts must lie in 1..65535");
   end

   logic wp_meta_reg;
   logic wp_sync_reg;
   logic status_write_disable_reg, status_write_disable_next;
   logic tb_reg, tb_next;
   logic [3:0] bp_reg, bp_next;
   logic wel_reg, wel_next;
   state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [7:0] status_rdata_next, flag_rdata_next, sfdp_data_next;
   logic rdata_valid_next, op_start_next, op_refused_next;
   cmd_t op_kind_next;
   logic [ADDR_W-1:0] op_addr_next;
   logic [1:0] bank_sel_next;
   logic [8:0] sector_idx_next;
   logic [9:0] sub32_idx_next;
   logic [12:0] sub4_idx_next;
   logic [ADDR_W-1:0] addr_m;
   logic [7:0] status_now;
   logic take, hw_locked, is_array_op, prot_hit;
   logic [31:0] density_word;

   // protected block test, 128KB granularity in both sector modes
   function automatic logic blk_protected(input logic [3:0] code, input logic tb,
                                          input logic [7:0] blk, input logic [8:0] total);
      logic [8:0] count;
      logic [8:0] blk9;
      count = 9'h000;
      blk9 = {1'b0, blk};
      if (code == 4'h0) begin
         count = 9'h000;
      end else if (code >= BP_ALL_CODE) begin
         count = total;
      end else begin
         count = 9'h001 << (code - 4'h1);
      end
      if (count > total) begin
         count = total;
      end
      if (tb) begin
         blk_protected = blk9 < count;
      end else begin
         blk_protected = blk9 >= (total - count);
      end
   endfunction

   // two flops before the protect pin is looked at
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
      end else if (clk_en) begin
         wp_meta_reg <= wp_n;
         wp_sync_reg <= wp_meta_reg;
      end
   end

   always_comb begin
      // 128Mb part has no address bit 24
      addr_m = cmd_addr;
      if (!DENSITY_256) begin
         addr_m[ADDR_W-1] = 1'b0;
      end
      busy = (state_reg == ST_BUSY);
      status_now = 8'h00;
      status_now[SR_STATUS_WRITE_DISABLE_BIT] = status_write_disable_reg;
      status_now[SR_BP_HI] = bp_reg[3];
      status_now[SR_TB_BIT] = tb_reg;
      status_now[SR_BP_LO+2:SR_BP_LO] = bp_reg[2:0];
      status_now[SR_WEL_BIT] = wel_reg;
      status_now[SR_BUSY_BIT] = busy;
      // status reads stay open while busy so the host can poll
      cmd_ready = !busy || cmd_op == CMD_READ_STATUS || cmd_op == CMD_READ_FLAG;
      take = cmd_valid && cmd_ready;
      hw_locked = status_write_disable_reg && !wp_sync_reg;
      is_array_op = cmd_op == CMD_PROGRAM || cmd_op == CMD_ERASE_SECTOR ||
                    cmd_op == CMD_ERASE_SUB32 || cmd_op == CMD_ERASE_SUB4;
      prot_hit = blk_protected(bp_reg, tb_reg, addr_m[ADDR_W-1:BLK128_LSB],
                               DENSITY_256 ? BLOCKS_256 : BLOCKS_128);
      status_write_disable_next = status_write_disable_reg;
      tb_next = tb_reg;
      bp_next = bp_reg;
      wel_next = wel_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      status_rdata_next = status_rdata;
      flag_rdata_next = flag_rdata;
      rdata_valid_next = 1'b0;
      op_start_next = 1'b0;
      op_refused_next = 1'b0;
      op_kind_next = op_kind;
      op_addr_next = op_addr;
      bank_sel_next = bank_sel;
      sector_idx_next = sector_idx;
      sub32_idx_next = sub32_idx;
      sub4_idx_next = sub4_idx;
      if (state_reg == ST_BUSY) begin
         if (cnt_reg <= 16'h0001) begin
            state_next = ST_IDLE;
            cnt_next = 16'h0000;
         end else begin
            cnt_next = cnt_reg - 16'h0001;
         end
      end
      if (take) begin
         case (cmd_op)
            CMD_READ_STATUS, CMD_READ_FLAG: begin
               status_rdata_next = status_now;
               flag_rdata_next = 8'h00;
               flag_rdata_next[FSR_READY_BIT] = !busy;
               rdata_valid_next = 1'b1;
            end
            CMD_WRITE_ENABLE: begin
               wel_next = 1'b1;
            end
            CMD_WRITE_DISABLE: begin
               wel_next = 1'b0;
            end
            CMD_WRITE_STATUS: begin
               if (wel_reg && !hw_locked) begin
                  status_write_disable_next = cmd_wdata[SR_STATUS_WRITE_DISABLE_BIT];
                  tb_next = cmd_wdata[SR_TB_BIT];
                  bp_next = {cmd_wdata[SR_BP_HI], cmd_wdata[SR_BP_LO+2:SR_BP_LO]};
                  wel_next = 1'b0;
                  state_next = ST_BUSY;
                  cnt_next = 16'(WRSR_CYCLES);
               end else begin
                  op_refused_next = 1'b1;
               end
            end
            CMD_WRITE_NVCFG: begin
               if (wel_reg) begin
                  wel_next = 1'b0;
                  op_start_next = 1'b1;
                  op_kind_next = cmd_op;
                  state_next = ST_BUSY;
                  cnt_next = 16'(NVCFG_CYCLES);
               end else begin
                  op_refused_next = 1'b1;
               end
            end
            CMD_ERASE_CHIP: begin
               if (wel_reg && bp_reg == 4'h0) begin
                  wel_next = 1'b0;
                  op_start_next = 1'b1;
                  op_kind_next = cmd_op;
                  op_addr_next = '0;
                  state_next = ST_BUSY;
                  cnt_next = 16'(ERASE_CYCLES);
               end else begin
                  // a protected attempt still drops the latch, busy never rises
                  wel_next = 1'b0;
                  op_refused_next = 1'b1;
               end
            end
            default: begin
               if (is_array_op && wel_reg && !prot_hit) begin
                  wel_next = 1'b0;
                  op_start_next = 1'b1;
                  op_kind_next = cmd_op;
                  op_addr_next = addr_m;
                  bank_sel_next = DENSITY_256 ? addr_m[BANK_LSB_256+1:BANK_LSB_256]
                                              : addr_m[BANK_LSB_128+1:BANK_LSB_128];
                  sector_idx_next = SECTOR_64K ? addr_m[ADDR_W-1:SEC64_LSB]
                                               : {1'b0, addr_m[ADDR_W-1:BLK128_LSB]};
                  sub32_idx_next = addr_m[ADDR_W-1:SUB32_LSB];
                  sub4_idx_next = addr_m[ADDR_W-1:SUB4_LSB];
                  state_next = ST_BUSY;
                  cnt_next = (cmd_op == CMD_PROGRAM) ? 16'(PROG_CYCLES) : 16'(ERASE_CYCLES);
               end else if (is_array_op) begin
                  wel_next = prot_hit ? 1'b0 : wel_reg;
                  op_refused_next = 1'b1;
               end
            end
         endcase
      end
   end

   // parameter table: signature, one header, two-dword basic table
   always_comb begin
      density_word = DENSITY_256 ? SFDP_DENSITY_256 : SFDP_DENSITY_128;
      sfdp_data_next = 8'hFF;
      case (sfdp_addr)
         8'h00: sfdp_data_next = 8'h53;
         8'h01: sfdp_data_next = 8'h46;
         8'h02: sfdp_data_next = 8'h44;
         8'h03: sfdp_data_next = 8'h50;
         8'h04: sfdp_data_next = 8'h00;
         8'h05: sfdp_data_next = 8'h01;
         8'h06: sfdp_data_next = 8'h00;
         8'h07: sfdp_data_next = 8'hFF;
         8'h08: sfdp_data_next = SFDP_PARAM_ID[7:0];
         8'h09: sfdp_data_next = 8'h00;
         8'h0A: sfdp_data_next = 8'h01;
         8'h0B: sfdp_data_next = SFDP_TABLE_DWORDS;
         8'h0C: sfdp_data_next = SFDP_TABLE_PTR;
         8'h0D: sfdp_data_next = 8'h00;
         8'h0E: sfdp_data_next = 8'h00;
         8'h0F: sfdp_data_next = SFDP_PARAM_ID[15:8];
         8'h30: sfdp_data_next = 8'hE5;
         8'h31: sfdp_data_next = 8'h20;
         8'h32: sfdp_data_next = 8'hFB;
         8'h33: sfdp_data_next = 8'hFF;
         8'h34: sfdp_data_next = density_word[7:0];
         8'h35: sfdp_data_next = density_word[15:8];
         8'h36: sfdp_data_next = density_word[23:16];
         8'h37: sfdp_data_next = density_word[31:24];
         default: sfdp_data_next = 8'hFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_write_disable_reg <= STATUS_WRITE_DISABLE_RESET;
         tb_reg <= TB_RESET;
         bp_reg <= BP_RESET;
         wel_reg <= WEL_RESET;
         state_reg <= ST_IDLE;
         cnt_reg <= 16'h0000;
         status_rdata <= 8'h00;
         flag_rdata <= 8'h00;
         rdata_valid <= 1'b0;
         op_start <= 1'b0;
         op_refused <= 1'b0;
         op_kind <= CMD_READ_STATUS;
         op_addr <= '0;
         bank_sel <= 2'h0;
         sector_idx <= 9'h000;
         sub32_idx <= 10'h000;
         sub4_idx <= 13'h0000;
         sfdp_data <= 8'hFF;
      end else if (clk_en) begin
         status_write_disable_reg <= status_write_disable_next;
         tb_reg <= tb_next;
         bp_reg <= bp_next;
         wel_reg <= wel_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         status_rdata <= status_rdata_next;
         flag_rdata <= flag_rdata_next;
         rdata_valid <= rdata_valid_next;
         op_start <= op_start_next;
         op_refused <= op_refused_next;
         op_kind <= op_kind_next;
         op_addr <= op_addr_next;
         bank_sel <= bank_sel_next;
         sector_idx <= sector_idx_next;
         sub32_idx <= sub32_idx_next;
         sub4_idx <= sub4_idx_next;
         sfdp_data <= sfdp_data_next;
      end
   end
endmodule

// ===== flash_prot_properties.sv
// checker bound to the status/protection block: handshake, busy length, refusals, mapping
// assumes one clock domain and sees only the block's ports
`timescale 1ns/1ns
module flash_prot_checker #(
   parameter bit DENSITY_256 = 1'b1,
   parameter bit SECTOR_64K = 1'b0,
   parameter int WRSR_CYCLES = 16,
   parameter int NVCFG_CYCLES = 16,
   parameter int PROG_CYCLES = 32,
   parameter int ERASE_CYCLES = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cmd_ready,
   input wire logic [7:0] status_rdata,
   input wire logic [7:0] flag_rdata,
   input wire logic rdata_valid,
   input wire flash_prot_pkg::cmd_t cmd_op,
   input wire logic op_start,
   input wire flash_prot_pkg::cmd_t op_kind,
   input wire logic [flash_prot_pkg::ADDR_W-1:0] op_addr,
   input wire logic op_refused,
   input wire logic [1:0] bank_sel,
   input wire logic [8:0] sector_idx,
   input wire logic busy,
   input wire logic [7:0] sfdp_addr,
   input wire logic [7:0] sfdp_data
);
   import flash_prot_pkg::*;
   // repetition counts cannot follow a parameter, so busy runs are counted here
   int run_len;
   int exp_len;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_len <= 0;
         exp_len <= 0;
      end else if (clk_en) begin
         run_len <= busy ? run_len + 1 : 0;
         if (busy && run_len == 0)
            exp_len <= !op_start ? WRSR_CYCLES : op_kind == CMD_PROGRAM ? PROG_CYCLES :
               op_kind == CMD_WRITE_NVCFG ? NVCFG_CYCLES : ERASE_CYCLES;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   busy_run_length_a: assert property ($fell(busy) |-> run_len == exp_len)
      else $error("busy length wrong");
   ready_when_idle_a: assert property (!busy |-> cmd_ready)
      else $error("stall while idle");
   stall_while_busy_a: assert property (busy && cmd_op == CMD_PROGRAM |-> !cmd_ready)
      else $error("program taken while busy");
   start_then_busy_a: assert property (op_start |-> busy ##1 busy)
      else $error("no busy after start");
   refused_stays_ready_a: assert property (op_refused |-> !busy && !op_start)
      else $error("refused op went busy");
   bank_from_addr_a: assert property (op_start && op_kind == CMD_PROGRAM |->
      bank_sel == (DENSITY_256 ? op_addr[24:23] : op_addr[23:22])) else $error("bank wrong");
   sector_from_addr_a: assert property (op_start && op_kind == CMD_PROGRAM |->
      sector_idx == (SECTOR_64K ? op_addr[24:16] : {1'b0, op_addr[24:17]})) else $error("sector wrong");
   param_id_byte_a: assert property (clk_en && sfdp_addr == 8'h0F |=> sfdp_data == 8'hFF)
      else $error("parameter id wrong");
   // the high id byte alone equals the unmapped filler, so the low byte is watched too
   param_id_low_a: assert property (clk_en && sfdp_addr == 8'h08 |=> sfdp_data == 8'h00)
      else $error("parameter id low byte wrong");
   flag_busy_inverse_a: assert property (rdata_valid |-> flag_rdata[7] == !status_rdata[0])
      else $error("flag ready not inverse of busy");
   cover property (op_refused);
   cover property ($fell(busy));
   cover property (op_start && op_kind == CMD_ERASE_CHIP);
endmodule
bind flash_status_protect_banking flash_prot_checker #(.DENSITY_256(DENSITY_256),
   .SECTOR_64K(SECTOR_64K), .WRSR_CYCLES(WRSR_CYCLES), .NVCFG_CYCLES(NVCFG_CYCLES),
   .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_flash_prot_checker (.clk(clk),
   .rst_n(rst_n), .clk_en(clk_en), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .op_start(op_start),
   .op_kind(op_kind), .op_addr(op_addr), .op_refused(op_refused), .bank_sel(bank_sel),
   .sector_idx(sector_idx), .busy(busy), .sfdp_addr(sfdp_addr), .sfdp_data(sfdp_data),
   .status_rdata(status_rdata), .flag_rdata(flag_rdata), .rdata_valid(rdata_valid));

// ===== flash_host_model.sv
// host controller model: hands whole commands to the block
// assumes a command is taken at a rising edge with cmd_valid and cmd_ready high
`timescale 1ns/1ns
module flash_host_model (
   input wire logic clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output flash_prot_pkg::cmd_t cmd_op,
   output logic [flash_prot_pkg::ADDR_W-1:0] cmd_addr,
   output logic [7:0] cmd_wdata
);
   import flash_prot_pkg::*;
   int timeouts = 0;
   initial begin
      cmd_valid = 1'b0;
      cmd_op = CMD_READ_STATUS;
      cmd_addr = '0;
      cmd_wdata = 8'h00;
   end
   // held until the taking edge; ready judged at the falling edge before it
   task automatic issue(input cmd_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      do begin
         @(negedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 200);
      if (n >= 200)
         timeouts++;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // released address and data lines show the inverse so stale values never look valid; cmd_op keeps the last op
      cmd_addr = ~a;
      cmd_wdata = ~d;
   endtask
endmodule

// ===== tb_top.sv
// testbench: commands through the host model, checks reads, refusals and indexes
// assumes the checker binds itself; short busy counts keep the run brief
`timescale 1ns/1ns
module tb_top;
   import flash_prot_pkg::*;
   typedef struct {logic [7:0] sr; cmd_t op; logic [24:0] a; logic ok;} case_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic wp_n = 1'b1;
   logic [7:0] sfdp_addr = 8'h00;
   logic cmd_valid, cmd_ready, rdata_valid, op_start, op_refused, busy;
   cmd_t cmd_op, op_kind;
   logic [ADDR_W-1:0] cmd_addr, op_addr;
   logic [7:0] cmd_wdata, status_rdata, flag_rdata, sfdp_data;
   logic [1:0] bank_sel;
   logic [8:0] sector_idx;
   logic [9:0] sub32_idx;
   logic [12:0] sub4_idx;
   int n_fail = 0;
   int num_checks = 0;
   case_t cases [13] = '{
      '{8'h04, CMD_PROGRAM, 25'h1FFFFFF, 1'b0}, '{8'h04, CMD_PROGRAM, 25'h1FDFFFF, 1'b1},
      '{8'h24, CMD_PROGRAM, 25'h0, 1'b0}, '{8'h24, CMD_PROGRAM, 25'h1FE0000, 1'b1},
      '{8'h24, CMD_ERASE_CHIP, 25'h0, 1'b0}, '{8'h40, CMD_ERASE_SECTOR, 25'h1000000, 1'b0},
      '{8'h40, CMD_ERASE_SUB4, 25'h0FE0000, 1'b1}, '{8'h3C, CMD_ERASE_SUB32, 25'h07E0000, 1'b0},
      '{8'h3C, CMD_PROGRAM, 25'h0800000, 1'b1}, '{8'h44, CMD_ERASE_SUB32, 25'h0, 1'b0},
      '{8'h00, CMD_ERASE_CHIP, 25'h0, 1'b1}, '{8'h00, CMD_WRITE_NVCFG, 25'h0, 1'b1},
      '{8'h00, CMD_PROGRAM, 25'h1A5F000, 1'b1}};
   always #4 clk = ~clk;
   flash_status_protect_banking #(.WRSR_CYCLES(2), .NVCFG_CYCLES(2), .PROG_CYCLES(3), .ERASE_CYCLES(4))
      u_flash_status_protect_banking (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .wp_n(wp_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .status_rdata(status_rdata), .flag_rdata(flag_rdata),
      .rdata_valid(rdata_valid), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
      .op_refused(op_refused), .bank_sel(bank_sel), .sector_idx(sector_idx), .sub32_idx(sub32_idx),
      .sub4_idx(sub4_idx), .busy(busy), .sfdp_addr(sfdp_addr), .sfdp_data(sfdp_data));
   flash_host_model u_flash_host_model (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      n_fail += u_flash_host_model.timeouts;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmd(input cmd_t op, input logic [24:0] a, input logic [7:0] d);
      u_flash_host_model.issue(op, a, d);
   endtask
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n++ < 100) begin
         @(posedge clk);
         #1;
      end
      // a busy that never ends counts against the run
      if (n > 100)
         n_fail++;
   endtask
   task automatic rd(input logic [7:0] exp);
      cmd(CMD_READ_STATUS, '0, 8'h00);
      check("read valid", rdata_valid, 1'b1);
      check("status", status_rdata, exp);
      check("flag", flag_rdata, exp[0] ? 8'h00 : 8'h80);
   endtask
   task automatic wr_sr(input logic [7:0] v, input logic ok);
      cmd(CMD_WRITE_ENABLE, '0, 8'h00);
      cmd(CMD_WRITE_STATUS, '0, v);
      check("status write refused", op_refused, !ok);
      idle();
   endtask
   initial begin
      // far above the few hundred cycles the tests need
      #50000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd(8'h00);
      sfdp_addr = 8'h08;
      @(posedge clk);
      #1;
      check("parameter id low", sfdp_data, SFDP_PARAM_ID[7:0]);
      sfdp_addr = 8'h0F;
      @(posedge clk);
      #1;
      check("parameter id", sfdp_data, SFDP_PARAM_ID[15:8]);
      $display("test power_up done");
      cmd(CMD_WRITE_ENABLE, '0, 8'h00);
      cmd(CMD_WRITE_DISABLE, '0, 8'h00);
      cmd(CMD_READ_FLAG, '0, 8'h00);
      check("flag read", flag_rdata, 8'h80);
      check("latch dropped", status_rdata, 8'h00);
      cmd(CMD_PROGRAM, '0, 8'h00);
      check("program without latch", op_refused, 1'b1);
      cmd(CMD_WRITE_STATUS, '0, 8'h80);
      check("write without latch", op_refused, 1'b1);
      cmd(CMD_WRITE_ENABLE, '0, 8'h00);
      rd(8'h02);
      cmd(CMD_WRITE_STATUS, '0, 8'h80);
      rd(8'h81);
      idle();
      rd(8'h80);
      $display("test status_write done");
      wp_n = 1'b0;
      repeat (3) @(posedge clk);
      wr_sr(8'h00, 1'b0);
      rd(8'h82);
      wp_n = 1'b1;
      repeat (3) @(posedge clk);
      wr_sr(8'h04, 1'b1);
      rd(8'h04);
      $display("test hardware_lock done");
      foreach (cases[i]) begin
         wr_sr(cases[i].sr, 1'b1);
         cmd(CMD_WRITE_ENABLE, '0, 8'h00);
         cmd(cases[i].op, cases[i].a, 8'h00);
         check("op start", op_start, cases[i].ok);
         check("busy", busy, cases[i].ok);
         idle();
      end
      check("bank", bank_sel, 2'h3);
      check("sector", sector_idx, 9'h0D2);
      check("subsector 32k", sub32_idx, 10'h34B);
      check("subsector 4k", sub4_idx, 13'h1A5F);
      check("op kind", op_kind, CMD_PROGRAM);
      check("op addr", op_addr, 25'h1A5F000);
      $display("test protection done");
      tally_and_finish();
   end
endmodule
